/* src/ext_irq_defines.svh */
// register offsets, field widths and reset values for the external interrupt flag block
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH
`define OFS_PIN_FUNC_A 4'h0
`define OFS_PIN_FUNC_B 4'h1
`define OFS_WAKE_FUNC 4'h2
`define OFS_EDGE_SEL 4'h3
`define OFS_WAKE_EDGE 4'h4
`define OFS_EDGE_FLAGS 4'h5
`define OFS_WAKE_FLAGS 4'h6
`define OFS_IRQ_STATUS 4'h7
`define OFS_IRQ_MASK 4'h8
`define OFS_PIN_LEVEL 4'h9
`define EDGE_N 5
`define WAKE_N 8
`define RST_BYTE 8'h00
`define GUARD_CYCLES 2'h1
`define ST_EDGE_BIT 0
`define ST_WAKE_BIT 1
`endif

/* src/ext_irq_pkg.sv */
// types shared by the external interrupt flag block
package ext_irq_pkg;
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [5:0] adr;
    logic [31:0] dat;
  } wb_req_t;
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;
endpackage : ext_irq_pkg

/* src/pin_edge_flag.sv */
// one gated edge detector with its sticky request flag
`timescale 1ns/1ns
module pin_edge_flag (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pin and controls
  input wire logic pin_i,
  input wire logic func_sel_i,
  input wire logic rise_sel_i,
  // software clear of the flag
  input wire logic clr_i,
  // flag
  output logic flag_o
);
  logic gated_ff;
  logic nxt_gated;
  logic edge_hit;
  logic flag_ff;

  // deselected pin looks high, so a switch with the pin low makes an edge
  assign nxt_gated = func_sel_i ? pin_i : 1'b1; // R11
  assign edge_hit = rise_sel_i ? (nxt_gated & ~gated_ff) : (~nxt_gated & gated_ff); // R01 R09

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gated_ff <= 1'b1;
    end else begin
      gated_ff <= nxt_gated;
    end
  end

  // set wins over clear so no edge is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= 1'b0;
    end else if (edge_hit) begin
      flag_ff <= 1'b1; // R02 R03 R04
    end else if (clr_i) begin
      flag_ff <= 1'b0; // R10
    end
  end

  assign flag_o = flag_ff;

  a_gate_edge_set: assert property (@(posedge clk_i) disable iff (rst_i) // R09
    edge_hit |=> flag_o) else $error("edge did not set flag");
  a_switch_low_set: assert property (@(posedge clk_i) disable iff (rst_i) // R02
    (!pin_i && !rise_sel_i && func_sel_i && !$past(func_sel_i)) |=> flag_o)
    else $error("function switch with low pin did not set flag");
  a_switch_high_set: assert property (@(posedge clk_i) disable iff (rst_i) // R03
    (!pin_i && !$past(pin_i) && rise_sel_i && !func_sel_i && $past(func_sel_i)) |=> flag_o)
    else $error("function release with low pin did not set flag");
  a_no_self_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (flag_o && !clr_i) |=> flag_o) else $error("flag fell without clear");
endmodule : pin_edge_flag

/* src/ext_irq_flags.sv */
// external interrupt and wakeup request flags with pin function switching
//
// Contract
// R01 - function rewrite may set flag spuriously
// R02 - func 0to1, pin low, edge bit 0 sets
// R03 - func 1to0, pin low, edge bit 1 sets
// R04 - wakeup func 0to1 with pin low sets
// R05 - software clears flag after function change
// R06 - software masks, waits one instruction, clears
// R07 - clear right after function write ignored
// R08 - source may hold pins high instead
// R09 - selected pin, chosen edge sets flag
// R10 - flags clear only by software write 0
// R11 - deselected pin seen as high level
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`include "ext_irq_defines.svh"
module ext_irq_flags (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire ext_irq_pkg::wb_req_t wb_req_i,
  output ext_irq_pkg::wb_rsp_t wb_rsp_o,
  // pins
  input wire logic [4:0] edge_irq_pin_i,
  input wire logic [7:0] wakeup_pin_i,
  // flags and interrupt
  output logic [4:0] edge_irq_request_flags_o,
  output logic [7:0] wakeup_request_flags_o,
  output logic irq_o
);
  import ext_irq_pkg::*;

  initial begin
    if (`EDGE_N != 5 || `WAKE_N != 8) $error("unsupported pin counts");
  end

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [31:0] nxt_rdat;
  logic [3:0] reg_idx;
  logic wr_stb;
  logic wr_lane0;
  logic [7:0] wd;

  function automatic logic hit(input logic [3:0] idx, input logic [3:0] ofs);
    hit = (idx == ofs);
  endfunction : hit

  assign reg_idx = wb_req_i.adr[5:2];
  assign wr_stb = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ~ack_ff;
  assign wr_lane0 = wr_stb & wb_req_i.sel[0];
  assign wd = wb_req_i.dat[7:0];

  logic [3:0] pin_func_a_ff;
  logic pin_func_b_ff;
  logic [7:0] wake_func_ff;
  logic [4:0] edge_sel_ff;
  logic [7:0] wake_edge_ff;
  logic [1:0] irq_mask_ff;
  logic [1:0] guard_ff;
  logic [1:0] nxt_guard;
  logic func_wr;
  logic [7:0] wake_func_q_ff;
  logic [1:0] sts_ff;
  logic [1:0] sts_clr;

  assign func_wr = wr_lane0 & (hit(reg_idx, `OFS_PIN_FUNC_A) | hit(reg_idx, `OFS_PIN_FUNC_B)
                   | hit(reg_idx, `OFS_WAKE_FUNC));
  // a flag clear in the access right after a function write is dropped
  assign nxt_guard = func_wr ? `GUARD_CYCLES :
                     ((wb_req_i.cyc & wb_req_i.stb & ~ack_ff & guard_ff != 2'h0) ?
                      guard_ff - 2'h1 : guard_ff); // R07

  // ----------------------------------------
  // flag clears
  // ----------------------------------------
  logic clr_ok;
  logic [4:0] edge_clr;
  logic [7:0] wake_clr;
  logic [12:0] func_vec;
  logic [12:0] rise_vec;
  logic [12:0] pin_vec;
  logic [12:0] clr_vec;
  logic [12:0] flag_vec;

  assign clr_ok = wr_lane0 & (guard_ff == 2'h0); // R07
  // write 0 to a bit clears it, write 1 leaves it
  assign edge_clr = (clr_ok & hit(reg_idx, `OFS_EDGE_FLAGS)) ? ~wd[4:0] : 5'h00; // R10
  assign wake_clr = (clr_ok & hit(reg_idx, `OFS_WAKE_FLAGS)) ? ~wd : 8'h00; // R10

  assign func_vec = {wake_func_ff, pin_func_a_ff, pin_func_b_ff};
  assign rise_vec = {wake_edge_ff & wake_func_q_ff, edge_sel_ff}; // R04
  assign pin_vec = {wakeup_pin_i, edge_irq_pin_i};
  assign clr_vec = {wake_clr, edge_clr};

  genvar g;
  generate
    for (g = 0; g < 13; g = g + 1) begin : g_pin
      pin_edge_flag u_flag (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(pin_vec[g]),
        .func_sel_i(func_vec[g]),
        .rise_sel_i(rise_vec[g]),
        .clr_i(clr_vec[g]),
        .flag_o(flag_vec[g])
      );
    end
  endgenerate

  assign edge_irq_request_flags_o = flag_vec[4:0];
  assign wakeup_request_flags_o = flag_vec[12:5];

  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  logic [12:0] flag_q_ff;
  logic [12:0] flag_rise;
  assign flag_rise = flag_vec & ~flag_q_ff;
  assign sts_clr = (wr_lane0 & hit(reg_idx, `OFS_IRQ_STATUS)) ? wd[1:0] : 2'h0;
  assign irq_o = |(sts_ff & irq_mask_ff);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q_ff <= 13'h0000;
      sts_ff <= 2'h0;
    end else begin
      flag_q_ff <= flag_vec;
      sts_ff[`ST_EDGE_BIT] <= (|flag_rise[4:0]) | (sts_ff[`ST_EDGE_BIT] & ~sts_clr[0]);
      sts_ff[`ST_WAKE_BIT] <= (|flag_rise[12:5]) | (sts_ff[`ST_WAKE_BIT] & ~sts_clr[1]);
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_func_a_ff <= 4'h0;
      pin_func_b_ff <= 1'b0;
      wake_func_ff <= `RST_BYTE;
      edge_sel_ff <= 5'h00;
      wake_edge_ff <= `RST_BYTE;
      irq_mask_ff <= 2'h0;
      guard_ff <= 2'h0;
    end else begin
      guard_ff <= nxt_guard;
      if (wr_lane0 && hit(reg_idx, `OFS_PIN_FUNC_A)) pin_func_a_ff <= wd[4:1];
      if (wr_lane0 && hit(reg_idx, `OFS_PIN_FUNC_B)) pin_func_b_ff <= wd[0];
      if (wr_lane0 && hit(reg_idx, `OFS_WAKE_FUNC)) wake_func_ff <= wd;
      if (wr_lane0 && hit(reg_idx, `OFS_EDGE_SEL)) edge_sel_ff <= wd[4:0];
      if (wr_lane0 && hit(reg_idx, `OFS_WAKE_EDGE)) wake_edge_ff <= wd;
      if (wr_lane0 && hit(reg_idx, `OFS_IRQ_MASK)) irq_mask_ff <= wd[1:0];
    end
  end

  // ----------------------------------------
  // wakeup function history
  // ----------------------------------------
  // a wakeup pin switched on while low must set its flag whatever edge it watches,
  // so its edge choice only counts from the cycle after the switch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_func_q_ff <= `RST_BYTE;
    end else begin
      wake_func_q_ff <= wake_func_ff; // R04
    end
  end

  // ----------------------------------------
  // read data and ack
  // ----------------------------------------
  assign nxt_rdat =
    hit(reg_idx, `OFS_PIN_FUNC_A) ? {27'h0, pin_func_a_ff, 1'b0} :
    hit(reg_idx, `OFS_PIN_FUNC_B) ? {31'h0, pin_func_b_ff} :
    hit(reg_idx, `OFS_WAKE_FUNC) ? {24'h0, wake_func_ff} :
    hit(reg_idx, `OFS_EDGE_SEL) ? {27'h0, edge_sel_ff} :
    hit(reg_idx, `OFS_WAKE_EDGE) ? {24'h0, wake_edge_ff} :
    hit(reg_idx, `OFS_EDGE_FLAGS) ? {27'h0, flag_vec[4:0]} :
    hit(reg_idx, `OFS_WAKE_FLAGS) ? {24'h0, flag_vec[12:5]} :
    hit(reg_idx, `OFS_IRQ_STATUS) ? {30'h0, sts_ff} :
    hit(reg_idx, `OFS_IRQ_MASK) ? {30'h0, irq_mask_ff} :
    hit(reg_idx, `OFS_PIN_LEVEL) ? {19'h0, pin_vec} : 32'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ack_ff <= wb_req_i.cyc & wb_req_i.stb & ~ack_ff;
      rdat_ff <= nxt_rdat;
    end
  end

  assign wb_rsp_o.ack = ack_ff;
  assign wb_rsp_o.dat = rdat_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_guard_blocks_clr: assert property (@(posedge clk_i) disable iff (rst_i) // R07
    (wr_lane0 && hit(reg_idx, `OFS_EDGE_FLAGS) && guard_ff != 2'h0)
    |=> ((flag_vec[4:0] & $past(flag_vec[4:0])) == $past(flag_vec[4:0])))
    else $error("guarded clear dropped a flag");
  a_wake_switch_set: assert property (@(posedge clk_i) disable iff (rst_i) // R04
    (wr_lane0 && hit(reg_idx, `OFS_WAKE_FUNC) && wd[0] && !wake_func_ff[0]
     && !wakeup_pin_i[0]) ##1 !wakeup_pin_i[0] |=> flag_vec[5])
    else $error("wakeup switch missed");
  a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i) // R09
    ((((|flag_rise[4:0]) && irq_mask_ff[`ST_EDGE_BIT]) ||
      ((|flag_rise[12:5]) && irq_mask_ff[`ST_WAKE_BIT]))
     && !(wr_lane0 && hit(reg_idx, `OFS_IRQ_MASK))) |=> irq_o)
    else $error("irq not raised");
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i) // Wishbone port
    ack_ff |=> !ack_ff) else $error("ack held two cycles");
  a_guard_after_func: assert property (@(posedge clk_i) disable iff (rst_i) // R07
    func_wr |=> (guard_ff != 2'h0)) else $error("function write left no guard");
  a_wake_clear_ok: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    (clr_ok && hit(reg_idx, `OFS_WAKE_FLAGS) && !wd[0]
     && (wake_func_ff[0] == wake_func_q_ff[0]) && $stable(wakeup_pin_i[0]))
    |=> !flag_vec[5]) else $error("wakeup flag not cleared");
  a_status_wake_set: assert property (@(posedge clk_i) disable iff (rst_i) // R09
    (|flag_rise[12:5]) |=> sts_ff[`ST_WAKE_BIT]) else $error("wakeup status not set");
endmodule : ext_irq_flags

/* bench/pin_source.sv */
// behavioural signal source that drives the interrupt and wakeup pins
`timescale 1ns/1ns
module pin_source (
  // clock
  input wire logic clk_i,
  // commanded levels
  input wire logic [4:0] edge_lvl_i,
  input wire logic [7:0] wake_lvl_i,
  // pins
  output logic [4:0] edge_irq_pin_o,
  output logic [7:0] wakeup_pin_o
);
  // levels stay put between commands, so switching with pins held high sets nothing
  always_ff @(posedge clk_i) begin
    edge_irq_pin_o <= edge_lvl_i;
    wakeup_pin_o <= wake_lvl_i;
  end
endmodule : pin_source

/* bench/tb.sv */
// self-checking bench for the external interrupt flag block
`timescale 1ns/1ns
module tb;
  import ext_irq_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  logic [4:0] e_lvl = 5'h1f;
  logic [7:0] w_lvl = 8'hff;
  logic [4:0] e_pin;
  logic [7:0] w_pin;
  logic [4:0] e_flags;
  logic [7:0] w_flags;
  logic irq_o;
  logic [31:0] rd;
  int failures = 0;
  int n_tests = 0;
  always #5 clk_i = ~clk_i;
  pin_source src (.clk_i(clk_i), .edge_lvl_i(e_lvl), .wake_lvl_i(w_lvl),
    .edge_irq_pin_o(e_pin), .wakeup_pin_o(w_pin));
  ext_irq_flags uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .edge_irq_pin_i(e_pin), .wakeup_pin_i(w_pin), .edge_irq_request_flags_o(e_flags),
    .wakeup_request_flags_o(w_flags), .irq_o(irq_o));
  // ------------------------------
  // bus and check tasks
  // ------------------------------
  // waits for ack without a limit of its own; the watchdog ends a hang
  task automatic wb(input logic we, input logic [3:0] idx, input logic [7:0] wd);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, 4'h1, {idx, 2'h0}, {24'h0, wd}};
    do begin
      @(posedge clk_i);
    end while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
  endtask : wb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [3:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 8'h00);
    chk(rd, exp);
  endtask : rc
  // pins move one cycle behind the command; flags need one more, so wait three
  task automatic pins(input logic [4:0] e, input logic [7:0] w);
    @(posedge clk_i);
    e_lvl <= e;
    w_lvl <= w;
    repeat (3) @(posedge clk_i);
  endtask : pins
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : finish_test
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    pins(5'h00, 8'h00);
    chk(32'(e_flags), 32'h0);
    wb(1'b1, 4'h0, 8'h1e);
    wb(1'b1, 4'h5, 8'h00);
    pins(5'h00, 8'h00);
    chk(32'(e_flags), 32'h1e);
    wb(1'b1, 4'h1, 8'h01);
    pins(5'h00, 8'h00);
    chk(32'(e_flags), 32'h1f);
    rc(4'hf, 32'h0);
    wb(1'b1, 4'h5, 8'h1f);
    rc(4'h5, 32'h1f);
    wb(1'b1, 4'h8, 8'h01);
    chk(32'(irq_o), 32'h1);
    wb(1'b1, 4'h8, 8'h00);
    chk(32'(irq_o), 32'h0);
    wb(1'b1, 4'h5, 8'h00);
    rc(4'h5, 32'h0);
    wb(1'b1, 4'h7, 8'h01);
    rc(4'h7, 32'h0);
    wb(1'b1, 4'h3, 8'h1f);
    wb(1'b1, 4'h0, 8'h00);
    wb(1'b1, 4'h1, 8'h00);
    rc(4'h5, 32'h1f);
    wb(1'b1, 4'h5, 8'h00);
    pins(5'h1f, 8'h00);
    wb(1'b1, 4'h0, 8'h1e);
    wb(1'b1, 4'h1, 8'h01);
    pins(5'h00, 8'h00);
    chk(32'(e_flags), 32'h0);
    pins(5'h1f, 8'h00);
    chk(32'(e_flags), 32'h1f);
    rc(4'hf, 32'h0);
    wb(1'b1, 4'h5, 8'h00);
    wb(1'b1, 4'h3, 8'h00);
    pins(5'h00, 8'h00);
    chk(32'(e_flags), 32'h1f);
    wb(1'b1, 4'h2, 8'hff);
    rc(4'h6, 32'hff);
    rc(4'h7, 32'h3);
    wb(1'b1, 4'h8, 8'h02);
    chk(32'(irq_o), 32'h1);
    wb(1'b1, 4'h7, 8'h02);
    rc(4'h7, 32'h1);
    chk(32'(irq_o), 32'h0);
    wb(1'b1, 4'h6, 8'h00);
    chk(32'(w_flags), 32'h0);
    wb(1'b1, 4'h2, 8'h00);
    rc(4'h9, 32'h0);
    wb(1'b1, 4'h4, 8'hff);
    wb(1'b1, 4'h2, 8'h01);
    rc(4'h6, 32'h01);
    chk(32'(irq_o), 32'h1);
    wb(1'b1, 4'h6, 8'h00);
    pins(5'h1f, 8'h01);
    rc(4'h9, 32'h3f);
    rc(4'h6, 32'h01);
    finish_test();
  end
  // the whole sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    finish_test();
  end
endmodule : tb
